// ==== verilog/swe_status_unit.sv ====
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps

// How it works
// [RL1] four condition flags kept, updated by the arithmetic unit, driven out for tests
// [RL2] low eight bits are control; exceptions change them, privileged software may write
// [RL3] state bit one selects compact instructions and drives the state output
// [RL4] software never writes the state bit; writes leave it untouched
// [RL5] disable bits block normal and fast requests respectively
// [RL6] mode field encodings select user, fast, normal, supervisor, abort, undefined, system
// [RL7] software writes only listed modes; others need a reset
// [RL8] software preserves reserved bits; they read as zero here
// [RL9] one current word plus five saved words, none for user or system
// [RL10] fast mode banks registers 8 to 14; other exception modes bank 13 and 14
// [RL11] entry writes pc plus 4 or 8 into link; compact state adjusted
// [RL12] entry copies current word into the entered mode's saved word
// [RL13] entry forces mode, vectors fetch, sets disable bits as needed
// [RL14] entry from compact state switches back to 32-bit state
// [RL15] return copies saved word back into current word, restoring state bit
// [RL16] handlers return by link minus 4, 8 or nothing per exception
// [RL17] requester drives fast or normal request inputs low to interrupt
// [RL18] select low treats requests as asynchronous with an extra sync cycle
// [RL19] with fast enabled, synchronised fast request sampled at each instruction end
// [RL20] user mode cannot set either interrupt-disable bit
// [RL21] normal ranks below fast and is masked on fast entry
// [RL22] supervisor link value captured at reset is unpredictable
// [RL23] vectors: reset 0, undef 4, soft 8, pabort C, dabort 10, normal 18, fast 1C
// [RL24] priority: reset, data abort, fast, normal, prefetch abort, undefined or soft
// [RL25] reset release: supervisor mode, both disables set, state clear, fetch zero
// [RL26] flags in bits 31 to 28 as n z c v, control in 7 to 0
// [RL27] fast entry sets both disables; other entries set the normal disable
module swe_status_unit (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        instr_done,
	input  wire logic [31:0] pc_in,
	input  wire logic        data_abort,
	input  wire logic        prefetch_abort,
	input  wire logic        undefined_instr_trap,
	input  wire logic        software_trap,
	input  wire logic        exc_return,
	input  wire logic        flag_we,
	input  wire logic [3:0]  flag_in,
	input  wire logic        fast_request_low,
	input  wire logic        normal_request_low,
	input  wire logic        sync_request_select,
	output logic             vector_valid,
	output logic      [31:0] vector_addr,
	output logic             link_we,
	output logic      [31:0] link_value,
	output logic      [4:0]  link_mode,
	output logic      [4:0]  current_mode,
	output logic      [3:0]  cond_flags,
	output logic             fast_bank,
	output logic             private_bank,
	output logic             instr_state_output
);

	swe_pkg::swe_state_s st;
	swe_pkg::swe_state_s next_st;

	// bank index of a mode; bit 3 flags a mode that has a saved word
	function automatic logic [3:0] bank_of(input logic [4:0] mode);
		logic [3:0] r;
		r = 4'h0;
		case (mode)
			swe_pkg::MODE_FAST:   r = {1'b1, swe_pkg::BANK_FAST};   // [RL9]
			swe_pkg::MODE_NORMAL: r = {1'b1, swe_pkg::BANK_NORMAL};
			swe_pkg::MODE_SUPER:  r = {1'b1, swe_pkg::BANK_SUPER};
			swe_pkg::MODE_ABORT:  r = {1'b1, swe_pkg::BANK_ABORT};
			swe_pkg::MODE_UNDEF:  r = {1'b1, swe_pkg::BANK_UNDEF};
			default:              r = 4'h0;
		endcase
		return r;
	endfunction

	// return address offset by cause and instruction state
	function automatic logic [31:0] link_ofs(input swe_pkg::swe_exc_e c, input logic compact);
		logic [31:0] r;
		r = swe_pkg::LINK_OFS_4;
		case (c)
			swe_pkg::SWE_EXC_DABORT: r = swe_pkg::LINK_OFS_8;                     // [RL11]
			swe_pkg::SWE_EXC_UNDEF,
			swe_pkg::SWE_EXC_SOFT:   r = compact ? swe_pkg::LINK_OFS_2 : swe_pkg::LINK_OFS_4;
			default:                 r = swe_pkg::LINK_OFS_4;
		endcase
		return r;
	endfunction

	// mode entered for each cause
	function automatic logic [4:0] mode_of(input swe_pkg::swe_exc_e c);
		logic [4:0] r;
		r = swe_pkg::MODE_SUPER;
		case (c)
			swe_pkg::SWE_EXC_DABORT,
			swe_pkg::SWE_EXC_PABORT: r = swe_pkg::MODE_ABORT;
			swe_pkg::SWE_EXC_FAST:   r = swe_pkg::MODE_FAST;
			swe_pkg::SWE_EXC_NORMAL: r = swe_pkg::MODE_NORMAL;
			swe_pkg::SWE_EXC_UNDEF:  r = swe_pkg::MODE_UNDEF;
			default:                 r = swe_pkg::MODE_SUPER;
		endcase
		return r;
	endfunction

	// vector address for each cause
	function automatic logic [31:0] vector_of(input swe_pkg::swe_exc_e c);
		logic [31:0] r;
		r = swe_pkg::VEC_RESET;
		case (c)
			swe_pkg::SWE_EXC_DABORT: r = swe_pkg::VEC_DABORT;   // [RL23]
			swe_pkg::SWE_EXC_FAST:   r = swe_pkg::VEC_FAST;
			swe_pkg::SWE_EXC_NORMAL: r = swe_pkg::VEC_NORMAL;
			swe_pkg::SWE_EXC_PABORT: r = swe_pkg::VEC_PABORT;
			swe_pkg::SWE_EXC_UNDEF:  r = swe_pkg::VEC_UNDEF;
			swe_pkg::SWE_EXC_SOFT:   r = swe_pkg::VEC_SOFT;
			default:                 r = swe_pkg::VEC_RESET;
		endcase
		return r;
	endfunction

	logic             privileged;
	logic [3:0]       cur_bank;
	logic             fast_seen_low;
	logic             norm_seen_low;
	logic             fast_take;
	logic             norm_take;
	swe_pkg::swe_exc_e cause;
	logic             apb_setup;
	logic             apb_access;
	logic             addr_ok;

	assign privileged = st.csw[swe_pkg::MODE_MSB:0] != swe_pkg::MODE_USER;
	assign cur_bank   = bank_of(st.csw[swe_pkg::MODE_MSB:0]);

	// select low adds one more stage for asynchronous requests
	assign fast_seen_low = st.sel_sync[1] ? ~st.fast_sync[1] : ~st.fast_late;   // [RL18]
	assign norm_seen_low = st.sel_sync[1] ? ~st.norm_sync[1] : ~st.norm_late;   // [RL18]

	// requests ignored while their disable bit is set
	assign fast_take = fast_seen_low & ~st.csw[swe_pkg::FAST_DIS_BIT];   // [RL5] [RL19]
	assign norm_take = norm_seen_low & ~st.csw[swe_pkg::NORM_DIS_BIT];   // [RL5]

	// fixed priority among causes at instruction end
	always_comb begin
		cause = swe_pkg::SWE_EXC_NONE;
		if (st.reset_entry) begin
			cause = swe_pkg::SWE_EXC_RESET;                        // [RL24]
		end else if (instr_done) begin
			if (data_abort) begin
				cause = swe_pkg::SWE_EXC_DABORT;                   // [RL24]
			end else if (fast_take) begin
				cause = swe_pkg::SWE_EXC_FAST;                     // [RL19] [RL21]
			end else if (norm_take) begin
				cause = swe_pkg::SWE_EXC_NORMAL;                   // [RL21]
			end else if (prefetch_abort) begin
				cause = swe_pkg::SWE_EXC_PABORT;
			end else if (undefined_instr_trap) begin
				cause = swe_pkg::SWE_EXC_UNDEF;
			end else if (software_trap) begin
				cause = swe_pkg::SWE_EXC_SOFT;
			end
		end
	end

	assign apb_setup  = psel & ~penable;
	assign apb_access = psel & penable;
	assign addr_ok    = (paddr == swe_pkg::ADDR_CURRENT) || (paddr == swe_pkg::ADDR_SAVED) ||
	                    (paddr == swe_pkg::ADDR_LINK) || (paddr == swe_pkg::ADDR_CAUSE);

	always_comb begin
		logic [31:0] wr_word;
		logic [3:0]  new_bank;
		logic [4:0]  new_mode;
		wr_word  = 32'h0000_0000;
		new_bank = 4'h0;
		new_mode = 5'h00;
		next_st  = st;

		// two flops on each request pin and on the select pin before any logic
		next_st.fast_sync = {st.fast_sync[0], fast_request_low};
		next_st.norm_sync = {st.norm_sync[0], normal_request_low};
		next_st.sel_sync  = {st.sel_sync[0], sync_request_select};
		next_st.fast_late = st.fast_sync[1];                               // [RL18]
		next_st.norm_late = st.norm_sync[1];                               // [RL18]

		next_st.vector_valid = 1'b0;
		next_st.link_we      = 1'b0;
		next_st.reset_entry  = 1'b0;

		// read data and error captured in setup, shown in access
		if (apb_setup) begin
			next_st.pslverr = ~addr_ok;
			if (paddr == swe_pkg::ADDR_CURRENT) begin
				next_st.prdata = st.csw & swe_pkg::WORD_MASK;              // [RL8]
			end else if (paddr == swe_pkg::ADDR_SAVED) begin
				next_st.prdata = cur_bank[3] ? st.saved[cur_bank[2:0]] : 32'h0000_0000;
			end else if (paddr == swe_pkg::ADDR_LINK) begin
				next_st.prdata = st.link_value;
			end else if (paddr == swe_pkg::ADDR_CAUSE) begin
				next_st.prdata = {24'h00_0000, st.last_cause};
			end else begin
				next_st.prdata = 32'h0000_0000;
			end
		end

		// flag update from the arithmetic unit
		if (flag_we) begin
			next_st.csw[swe_pkg::FLAG_N_BIT:swe_pkg::FLAG_LSB] = flag_in;  // [RL1] [RL26]
		end

		// software writes, taken in the access phase
		if (apb_access && pwrite && addr_ok) begin
			if (paddr == swe_pkg::ADDR_CURRENT) begin
				wr_word = pwdata & swe_pkg::WORD_MASK;                     // [RL8]
				if (privileged) begin
					next_st.csw = wr_word;                                 // [RL2] [RL7]
					next_st.csw[swe_pkg::STATE_BIT] = st.csw[swe_pkg::STATE_BIT];  // [RL4]
				end else begin
					// user keeps the control group untouched
					next_st.csw = (wr_word & swe_pkg::FLAG_MASK) |
					              (st.csw & swe_pkg::CTRL_MASK);           // [RL20]
				end
			end else if (paddr == swe_pkg::ADDR_SAVED) begin
				if (privileged && cur_bank[3]) begin
					next_st.saved[cur_bank[2:0]] = pwdata & swe_pkg::WORD_MASK;
				end
			end
		end

		// return restores the current word from the saved word
		if (exc_return && cur_bank[3]) begin
			next_st.csw = st.saved[cur_bank[2:0]];                         // [RL15]
		end

		// exception entry overrides mode, state, normal disable, fast disable on fast or reset, and the entered saved word; flag updates this cycle stay
		if (cause != swe_pkg::SWE_EXC_NONE) begin
			new_mode = mode_of(cause);                                     // [RL6]
			new_bank = bank_of(new_mode);
			next_st.saved[new_bank[2:0]] = st.csw;                         // [RL12] [RL22]
			next_st.csw[swe_pkg::MODE_MSB:0] = new_mode;                   // [RL13]
			next_st.csw[swe_pkg::STATE_BIT] = 1'b0;                        // [RL14] [RL25]
			next_st.csw[swe_pkg::NORM_DIS_BIT] = 1'b1;                     // [RL21] [RL27]
			if (cause == swe_pkg::SWE_EXC_FAST || cause == swe_pkg::SWE_EXC_RESET) begin
				next_st.csw[swe_pkg::FAST_DIS_BIT] = 1'b1;                 // [RL25] [RL27]
			end
			next_st.link_value = pc_in + link_ofs(cause, st.csw[swe_pkg::STATE_BIT]);  // [RL11]
			next_st.link_mode    = new_mode;
			next_st.link_we      = 1'b1;
			next_st.vector_addr  = vector_of(cause);                       // [RL13] [RL23]
			next_st.vector_valid = 1'b1;
			next_st.last_cause   = cause;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st.csw          <= swe_pkg::CSW_RESET;                         // [RL25]
			st.saved        <= {swe_pkg::NUM_SAVED{swe_pkg::SAVED_RESET}};
			st.fast_sync    <= 2'h3;
			st.norm_sync    <= 2'h3;
			st.sel_sync     <= 2'h0;
			st.fast_late    <= 1'b1;
			st.norm_late    <= 1'b1;
			st.reset_entry  <= 1'b1;                                       // [RL25]
			st.vector_valid <= 1'b0;
			st.vector_addr  <= swe_pkg::VEC_RESET;
			st.link_we      <= 1'b0;
			st.link_value   <= 32'h0000_0000;
			st.link_mode    <= swe_pkg::MODE_SUPER;
			st.last_cause   <= swe_pkg::SWE_EXC_NONE;
			st.prdata       <= 32'h0000_0000;
			st.pslverr      <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// zero wait state slave
	assign pready  = 1'b1;
	assign prdata  = st.prdata;
	assign pslverr = st.pslverr & apb_access;

	assign vector_valid       = st.vector_valid;
	assign vector_addr        = st.vector_addr;
	assign link_we            = st.link_we;
	assign link_value         = st.link_value;
	assign link_mode          = st.link_mode;
	assign current_mode       = st.csw[swe_pkg::MODE_MSB:0];                       // [RL6]
	assign cond_flags         = st.csw[swe_pkg::FLAG_N_BIT:swe_pkg::FLAG_LSB];     // [RL1]
	assign instr_state_output = st.csw[swe_pkg::STATE_BIT];                        // [RL3]
	assign fast_bank          = st.csw[swe_pkg::MODE_MSB:0] == swe_pkg::MODE_FAST; // [RL10]
	assign private_bank       = cur_bank[3] & ~fast_bank;                          // [RL10]

endmodule

// ==== verilog/swe_pkg.sv ====
package swe_pkg;

	// register offsets (byte addresses)
	localparam logic [7:0]  ADDR_CURRENT    = 8'h00;
	localparam logic [7:0]  ADDR_SAVED      = 8'h04;
	localparam logic [7:0]  ADDR_LINK       = 8'h08;
	localparam logic [7:0]  ADDR_CAUSE      = 8'h0C;

	// status word layout
	localparam int          FLAG_N_BIT      = 31;
	localparam int          FLAG_Z_BIT      = 30;
	localparam int          FLAG_C_BIT      = 29;
	localparam int          FLAG_V_BIT      = 28;
	localparam int          FLAG_LSB        = 28;
	localparam int          NORM_DIS_BIT    = 7;
	localparam int          FAST_DIS_BIT    = 6;
	localparam int          STATE_BIT       = 5;
	localparam int          MODE_MSB        = 4;
	localparam int          CTRL_MSB        = 7;
	localparam logic [31:0] WORD_MASK       = 32'hF000_00FF;
	localparam logic [31:0] FLAG_MASK       = 32'hF000_0000;
	localparam logic [31:0] CTRL_MASK       = 32'h0000_00FF;
	localparam logic [31:0] CSW_RESET       = 32'h0000_00D3;
	localparam logic [31:0] SAVED_RESET     = 32'h0000_0000;

	// mode encodings
	localparam logic [4:0]  MODE_USER       = 5'h10;
	localparam logic [4:0]  MODE_FAST       = 5'h11;
	localparam logic [4:0]  MODE_NORMAL     = 5'h12;
	localparam logic [4:0]  MODE_SUPER      = 5'h13;
	localparam logic [4:0]  MODE_ABORT      = 5'h17;
	localparam logic [4:0]  MODE_UNDEF      = 5'h1B;
	localparam logic [4:0]  MODE_SYSTEM     = 5'h1F;

	// saved status word banks
	localparam int          NUM_SAVED       = 5;
	localparam logic [2:0]  BANK_FAST       = 3'h0;
	localparam logic [2:0]  BANK_NORMAL     = 3'h1;
	localparam logic [2:0]  BANK_SUPER      = 3'h2;
	localparam logic [2:0]  BANK_ABORT      = 3'h3;
	localparam logic [2:0]  BANK_UNDEF      = 3'h4;

	// exception vectors
	localparam logic [31:0] VEC_RESET       = 32'h0000_0000;
	localparam logic [31:0] VEC_UNDEF       = 32'h0000_0004;
	localparam logic [31:0] VEC_SOFT        = 32'h0000_0008;
	localparam logic [31:0] VEC_PABORT      = 32'h0000_000C;
	localparam logic [31:0] VEC_DABORT      = 32'h0000_0010;
	localparam logic [31:0] VEC_NORMAL      = 32'h0000_0018;
	localparam logic [31:0] VEC_FAST        = 32'h0000_001C;

	// return address offsets
	localparam logic [31:0] LINK_OFS_2      = 32'h0000_0002;
	localparam logic [31:0] LINK_OFS_4      = 32'h0000_0004;
	localparam logic [31:0] LINK_OFS_8      = 32'h0000_0008;

	typedef enum logic [7:0] {
		SWE_EXC_NONE   = 8'h01,
		SWE_EXC_RESET  = 8'h02,
		SWE_EXC_DABORT = 8'h04,
		SWE_EXC_FAST   = 8'h08,
		SWE_EXC_NORMAL = 8'h10,
		SWE_EXC_PABORT = 8'h20,
		SWE_EXC_UNDEF  = 8'h40,
		SWE_EXC_SOFT   = 8'h80
	} swe_exc_e;

	typedef struct packed {
		logic [31:0]           csw;
		logic [4:0][31:0]      saved;
		logic [1:0]            fast_sync;
		logic [1:0]            norm_sync;
		logic [1:0]            sel_sync;
		logic                  fast_late;
		logic                  norm_late;
		logic                  reset_entry;
		logic                  vector_valid;
		logic [31:0]           vector_addr;
		logic                  link_we;
		logic [31:0]           link_value;
		logic [4:0]            link_mode;
		logic [7:0]            last_cause;
		logic [31:0]           prdata;
		logic                  pslverr;
	} swe_state_s;

endpackage

// ==== verif/swe_sva.sv ====
`timescale 1ns/100ps
module swe_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        pwrite,
	input wire logic        instr_done,
	input wire logic [31:0] pc_in,
	input wire logic        exc_return,
	input wire logic        flag_we,
	input wire logic [3:0]  flag_in,
	input wire logic        vector_valid,
	input wire logic [31:0] vector_addr,
	input wire logic        link_we,
	input wire logic [31:0] link_value,
	input wire logic [4:0]  link_mode,
	input wire logic [4:0]  current_mode,
	input wire logic [3:0]  cond_flags,
	input wire logic        fast_bank,
	input wire logic        private_bank
);
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_bank_fast: assert property (fast_bank == (current_mode == 5'h11))
		else $error("fast bank flag wrong");
	a_bank_private: assert property (private_bank ==
		(current_mode inside {5'h12, 5'h13, 5'h17, 5'h1B})) else $error("private bank flag wrong");
	a_link_pair: assert property (link_we == vector_valid) else $error("link write unpaired");
	a_mode_match: assert property (vector_valid |-> link_mode == current_mode)
		else $error("entry mode mismatch");
	a_entry_cause: assert property (vector_valid && vector_addr != 32'h0000_0000
		|-> $past(instr_done)) else $error("entry without instruction end");
	a_fast_link: assert property (vector_valid && vector_addr == 32'h0000_001C
		|-> link_value == $past(pc_in) + 32'h0000_0004 && current_mode == 5'h11)
		else $error("fast entry link wrong");
	a_dab_link: assert property (vector_valid && vector_addr == 32'h0000_0010
		|-> link_value == $past(pc_in) + 32'h0000_0008 && current_mode == 5'h17)
		else $error("data abort link wrong");
	a_flag_load: assert property (flag_we && !exc_return && !(psel && pwrite)
		|=> cond_flags == $past(flag_in)) else $error("flags not loaded");
endmodule

// ==== verif/swe_irq_model.sv ====
`timescale 1ns/100ps
module swe_irq_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic want_fast,
	input  wire logic want_norm,
	output logic      fast_request_low,
	output logic      normal_request_low
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			{fast_request_low, normal_request_low} <= 2'h3;
		else
			{fast_request_low, normal_request_low} <= ~{want_fast, want_norm};
	end
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, instr_done, flag_we;
	logic        data_abort, prefetch_abort, undefined_instr_trap, software_trap, exc_return;
	logic        fast_request_low, normal_request_low, sync_request_select, vector_valid;
	logic        link_we, fast_bank, private_bank, instr_state_output, want_fast, want_norm;
	logic        err;
	logic [3:0]  flag_in, cond_flags;
	logic [4:0]  link_mode, current_mode;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, pc_in, vector_addr, link_value, rd;
	int          fail_count = 0, check_count = 0;
	swe_status_unit dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .instr_done, .pc_in, .data_abort, .prefetch_abort,
		.undefined_instr_trap, .software_trap, .exc_return, .flag_we, .flag_in,
		.fast_request_low, .normal_request_low, .sync_request_select, .vector_valid,
		.vector_addr, .link_we, .link_value, .link_mode, .current_mode, .cond_flags,
		.fast_bank, .private_bank, .instr_state_output);
	swe_irq_model irq_u (.pclk, .presetn, .want_fast, .want_norm, .fast_request_low,
		.normal_request_low);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		#20000;
		fail_count++;
		conclude();
	end
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task automatic rdchk(logic [7:0] a, logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(rd, e)
	endtask
	task automatic req(logic s, logic f, logic n, logic r);
		@(posedge pclk);
		{sync_request_select, want_fast, want_norm} <= {s, f, n};
		repeat (6) @(posedge pclk);
		exc_return <= r;
		@(posedge pclk);
		exc_return <= 1'b0;
	endtask
	task automatic step(logic [31:0] pc, logic [3:0] t, logic v, logic [31:0] va, lv, logic [4:0] m);
		@(posedge pclk);
		{instr_done, pc_in, data_abort, prefetch_abort, undefined_instr_trap, software_trap} <= {1'b1, pc, t};
		@(posedge pclk);
		{instr_done, data_abort, prefetch_abort, undefined_instr_trap, software_trap} <= 5'h00;
		#1;
		`CHK({vector_valid, v ? {vector_addr, link_value, current_mode} : 69'h0}, {v, va, lv, m})
	endtask
	task automatic t_reset();
		@(posedge pclk);
		#1;
		`CHK({vector_valid, vector_addr, link_mode}, {1'b1, 32'h0000_0000, 5'h13})
		rdchk(8'h00, 32'h0000_00D3);
		rdchk(8'h04, 32'h0000_00D3);
		rdchk(8'h0C, 32'h0000_0002);
	endtask
	task automatic t_ctrl();
		apb(1'b1, 8'h00, 32'h0000_0013);
		rdchk(8'h00, 32'h0000_0013);
		@(posedge pclk);
		{flag_we, flag_in} <= {1'b1, 4'h5};
		@(posedge pclk);
		flag_we <= 1'b0;
		#1;
		`CHK({cond_flags, instr_state_output}, {4'h5, 1'b0})
		rdchk(8'h00, 32'h5000_0013);
	endtask
	task automatic t_traps();
		logic [3:0]  tv [4] = '{4'hD, 4'h5, 4'h2, 4'h1};
		logic [31:0] va [4] = '{32'h0000_0010, 32'h0000_000C, 32'h0000_0004, 32'h0000_0008};
		logic [31:0] lo [4] = '{32'h0000_0008, 32'h0000_0004, 32'h0000_0004, 32'h0000_0004};
		logic [4:0]  md [4] = '{5'h17, 5'h17, 5'h1B, 5'h13};
		for (int i = 0; i < 4; i++) begin
			step(32'h0000_0100, tv[i], 1'b1, va[i], 32'h0000_0100 + lo[i], md[i]);
			rdchk(8'h04, 32'h5000_0013);
			rdchk(8'h00, {4'h5, 20'h0_0000, 3'h4, md[i]});
			req(1'b1, 1'b0, 1'b0, 1'b1);
			rdchk(8'h00, 32'h5000_0013);
		end
	endtask
	task automatic t_irq(logic s);
		req(s, 1'b1, 1'b1, 1'b0);
		step(32'h0000_0200, 4'h0, 1'b1, 32'h0000_001C, 32'h0000_0204, 5'h11);
		rdchk(8'h00, 32'h5000_00D1);
		step(32'h0000_0300, 4'h0, 1'b0, 32'h0, 32'h0, 5'h0);
		req(s, 1'b0, 1'b1, 1'b1);
		step(32'h0000_0400, 4'h0, 1'b1, 32'h0000_0018, 32'h0000_0404, 5'h12);
		rdchk(8'h00, 32'h5000_0092);
		step(32'h0000_0500, 4'h0, 1'b0, 32'h0, 32'h0, 5'h0);
		req(s, 1'b1, 1'b0, 1'b1);
		step(32'h0000_0600, 4'h8, 1'b1, 32'h0000_0010, 32'h0000_0608, 5'h17);
		step(32'h0000_0700, 4'h0, 1'b1, 32'h0000_001C, 32'h0000_0704, 5'h11);
		req(s, 1'b0, 1'b0, 1'b1);
		req(s, 1'b0, 1'b0, 1'b1);
		rdchk(8'h00, 32'h5000_0013);
	endtask
	task automatic t_user();
		apb(1'b1, 8'h00, 32'h0000_0010);
		rdchk(8'h00, 32'h0000_0010);
		apb(1'b1, 8'h00, 32'hA000_00D0);
		rdchk(8'h00, 32'hA000_0010);
		step(32'h0000_0800, 4'h1, 1'b1, 32'h0000_0008, 32'h0000_0804, 5'h13);
		rdchk(8'h04, 32'hA000_0010);
	endtask
	task automatic t_compact();
		apb(1'b1, 8'h04, 32'h0000_0030);
		req(1'b1, 1'b0, 1'b0, 1'b1);
		#1;
		`CHK({instr_state_output, current_mode}, {1'b1, 5'h10})
		step(32'h0000_0900, 4'h1, 1'b1, 32'h0000_0008, 32'h0000_0902, 5'h13);
		`CHK(instr_state_output, 1'b0)
		rdchk(8'h08, 32'h0000_0902);
		rdchk(8'h0C, 32'h0000_0080);
		`CHK(err, 1'b0)
		rdchk(8'h10, 32'h0000_0000);
		`CHK({err, pready}, 2'h3)
	endtask
	task automatic t_rerun();
		apb(1'b1, 8'h00, 32'h0000_0010);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
	endtask
	task automatic conclude();
		if (fail_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		{presetn, psel, penable, pwrite, instr_done, exc_return, flag_we, want_fast} = 8'h00;
		{want_norm, data_abort, prefetch_abort, undefined_instr_trap, software_trap} = 5'h00;
		{sync_request_select, paddr, pwdata, pc_in, flag_in} = {1'b1, 76'h0};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_ctrl();
		t_traps();
		t_irq(1'b1);
		t_irq(1'b0);
		t_user();
		t_compact();
		t_rerun();
		conclude();
	end
endmodule
bind swe_status_unit swe_sva chk_u (.*);
